// file: logic/cpss_params.svh
// Constants for the charge pump start-up sequencer
// Function
// - While the reset pin is high the block stays in reset with all state at defaults.
// - When the reset pin goes low the block enters standby.
// - With standby release and pump enable both set, wait 0.8 ms then start soft start.
// - Soft start ramps the output target from zero to the nominal level over 200 us.
// - Each new pump enable and each thermal recovery reruns delay and soft start.
// - Reaching 160 C enters thermal shutdown and stops the pump.
// - Falling to 140 C leaves thermal shutdown on its own.
// - The pump runs on two non-overlapping phases, charge then pump.
// - Multiplier select picks 1.5x at 4.5 V or 2x at 5.0 V, the ramp target.
`ifndef CPSS_PARAMS_SVH
`define CPSS_PARAMS_SVH
// ============================================
// Timing
`define CPSS_CLK_HZ 25000000
`define CPSS_DELAY_NS 800000
`define CPSS_RAMP_NS 200000
`define CPSS_DELAY_CYC (`CPSS_DELAY_NS / (1000000000 / `CPSS_CLK_HZ))
`define CPSS_RAMP_CYC (`CPSS_RAMP_NS / (1000000000 / `CPSS_CLK_HZ))
`define CPSS_CNT_W 16
// Pump phase: quarter-period slots, dead slot between phases
`define CPSS_SLOT_CYC 16'h0010
// ============================================
// Target levels, millivolts; thermal thresholds, degrees C
`define CPSS_LVL_W 13
`define CPSS_MV_15X 13'h1194
`define CPSS_MV_2X 13'h1388
`define CPSS_THERM_ENTER 8'hA0
`define CPSS_THERM_EXIT 8'h8C
`endif

// file: logic/cpss_pkg.sv
// Types for the charge pump start-up sequencer
`default_nettype none
package cpss_pkg;
  typedef enum logic [4:0] {
    CPSS_RESET = 5'h01,
    CPSS_STBY = 5'h02,
    CPSS_DELAY = 5'h04,
    CPSS_RAMP = 5'h08,
    CPSS_RUN = 5'h10
  } cpss_state_t;
endpackage
`default_nettype wire

// file: logic/cpss_sequencer.sv
// Charge pump start-up sequencer
`include "cpss_params.svh"
`default_nettype none
module cpss_sequencer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Reset pin, active high, asynchronous to clk_sys
  input wire logic resetInputPin,
  // Control bits
  input wire logic standbyReleaseBit,
  input wire logic pumpEnableBit,
  input wire logic multiplierSelect,
  // Junction temperature, degrees C
  input wire logic [7:0] junctionTemp,
  // Outputs
  output logic chargePhase,
  output logic pumpPhase,
  output logic [12:0] targetMv,
  output logic thermalShutdown,
  output logic [4:0] seqState
);
  // ============================================
  // Pin synchroniser
  logic rstMeta_r, rstSync_r;
  always_ff @(posedge clk_sys) begin
    rstMeta_r <= resetInputPin;
    rstSync_r <= rstMeta_r;
  end
  logic inReset;
  assign inReset = srst | rstSync_r;

  function automatic logic [12:0] nominalMv(input logic sel);
    nominalMv = sel ? `CPSS_MV_2X : `CPSS_MV_15X;
  endfunction

  // States in which the pump switches may be driven
  function automatic logic isPumping(input cpss_pkg::cpss_state_t s);
    isPumping = (s == cpss_pkg::CPSS_RAMP) || (s == cpss_pkg::CPSS_RUN);
  endfunction

  // ============================================
  // Sequencer
  cpss_pkg::cpss_state_t state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic therm_r, therm_nxt, enPrev_r;
  logic [12:0] tgt_r, tgt_nxt;
  logic enRise, active;
  assign enRise = pumpEnableBit & ~enPrev_r;
  assign active = standbyReleaseBit & pumpEnableBit & ~therm_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 16'h0001;
    therm_nxt = therm_r;
    tgt_nxt = tgt_r;
    if (junctionTemp >= `CPSS_THERM_ENTER) begin
      therm_nxt = 1'b1;
    end else if (junctionTemp <= `CPSS_THERM_EXIT) begin
      therm_nxt = 1'b0;
    end
    case (state_r)
      cpss_pkg::CPSS_RESET: begin
        state_nxt = cpss_pkg::CPSS_STBY;
        cnt_nxt = 16'h0000;
      end
      cpss_pkg::CPSS_STBY: begin
        cnt_nxt = 16'h0000;
        tgt_nxt = 13'h0000;
        if (active) begin
          state_nxt = cpss_pkg::CPSS_DELAY;
        end
      end
      cpss_pkg::CPSS_DELAY: begin
        tgt_nxt = 13'h0000;
        if (cnt_r == 16'(`CPSS_DELAY_CYC - 1)) begin
          state_nxt = cpss_pkg::CPSS_RAMP;
          cnt_nxt = 16'h0000;
        end
      end
      cpss_pkg::CPSS_RAMP: begin
        // Linear ramp; each step multiplies the nominal level by the step count and divides by CPSS_RAMP_CYC
        tgt_nxt = 13'((32'(nominalMv(multiplierSelect)) * 32'(cnt_r + 16'h0001))
          / `CPSS_RAMP_CYC);
        if (cnt_r == 16'(`CPSS_RAMP_CYC - 1)) begin
          state_nxt = cpss_pkg::CPSS_RUN;
          cnt_nxt = 16'h0000;
        end
      end
      cpss_pkg::CPSS_RUN: begin
        tgt_nxt = nominalMv(multiplierSelect);
        cnt_nxt = (cnt_r == 16'(4 * `CPSS_SLOT_CYC - 1)) ? 16'h0000 : cnt_nxt;
      end
      default: begin
        state_nxt = cpss_pkg::CPSS_STBY;
      end
    endcase
    // Leaving conditions override every running state
    if (state_r != cpss_pkg::CPSS_RESET && state_r != cpss_pkg::CPSS_STBY) begin
      if (!active) begin
        state_nxt = cpss_pkg::CPSS_STBY;
        tgt_nxt = 13'h0000;
      end else if (enRise || (therm_r && !therm_nxt)) begin
        state_nxt = cpss_pkg::CPSS_DELAY;
        cnt_nxt = 16'h0000;
        tgt_nxt = 13'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (inReset) begin
      state_r <= cpss_pkg::CPSS_RESET;
      cnt_r <= 16'h0000;
      therm_r <= 1'b0;
      tgt_r <= 13'h0000;
      enPrev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      therm_r <= therm_nxt;
      tgt_r <= tgt_nxt;
      enPrev_r <= pumpEnableBit;
    end
  end

  // ============================================
  // Phase generator
  // One dead slot after each phase keeps the switches from ever overlapping
  logic chg_r, pmp_r, chg_nxt, pmp_nxt;
  always_comb begin
    chg_nxt = 1'b0;
    pmp_nxt = 1'b0;
    // Looking at the next state too stops a restart leaking a phase into delay
    if (isPumping(state_r) && isPumping(state_nxt)) begin
      chg_nxt = cnt_r[5:4] == 2'h0;
      pmp_nxt = cnt_r[5:4] == 2'h2;
    end
    if (!active) begin
      chg_nxt = 1'b0;
      pmp_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (inReset) begin
      chg_r <= 1'b0;
      pmp_r <= 1'b0;
    end else begin
      chg_r <= chg_nxt;
      pmp_r <= pmp_nxt;
    end
  end

  assign chargePhase = chg_r;
  assign pumpPhase = pmp_r;
  assign targetMv = tgt_r;
  assign thermalShutdown = therm_r;
  assign seqState = state_r;
endmodule
`default_nettype wire

// file: verification/cpss_checker.sv
// Assertions for the charge pump start-up sequencer
`default_nettype none
module cpss_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Controls
  input wire logic resetInputPin,
  input wire logic standbyReleaseBit,
  input wire logic pumpEnableBit,
  input wire logic multiplierSelect,
  input wire logic [7:0] junctionTemp,
  // Outputs
  input wire logic chargePhase,
  input wire logic pumpPhase,
  input wire logic [12:0] targetMv,
  input wire logic thermalShutdown,
  input wire logic [4:0] seqState
);
  // One dwell counter times every state, so no per-state count is needed
  logic [4:0] prev_r;
  logic [15:0] dwell_r;
  always_ff @(posedge clk_sys) begin
    prev_r <= seqState;
    dwell_r <= (seqState == prev_r) ? dwell_r + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_PIN_RESET: assert property (
    resetInputPin [*3] |=> seqState == 5'h01 && targetMv == 13'h0000)
    else $error("pin reset not applied");
  AST_IDLE_PHASES: assert property (
    seqState < 5'h08 |-> !chargePhase && !pumpPhase)
    else $error("phase active while idle");
  AST_DEAD_SLOT: assert property (
    $fell(chargePhase) |-> !pumpPhase [*8])
    else $error("phases overlap");
  AST_DELAY: assert property (
    $rose(seqState[3]) |-> dwell_r == 16'h4E1F)
    else $error("start-up delay length");
  AST_RAMP: assert property (
    $rose(seqState[4]) |-> dwell_r == 16'h1387 &&
    targetMv == (multiplierSelect ? 13'h1388 : 13'h1194))
    else $error("ramp length or target");
  AST_HOT: assert property (
    junctionTemp >= 8'hA0 |-> ##[1:2] thermalShutdown)
    else $error("no shutdown");
  AST_COOL: assert property (
    thermalShutdown && junctionTemp <= 8'h8C |-> ##[1:2] !thermalShutdown)
    else $error("no recovery");
  AST_RERUN: assert property (
    $rose(pumpEnableBit) && standbyReleaseBit && !thermalShutdown
    |-> ##[1:2] seqState == 5'h04) else $error("no rerun");
  cover property (seqState == 5'h10);
  cover property ($rose(thermalShutdown));
  cover property ($fell(chargePhase));
endmodule
bind cpss_sequencer cpss_checker chk_u (.clk_sys, .srst, .resetInputPin,
  .standbyReleaseBit, .pumpEnableBit, .multiplierSelect, .junctionTemp,
  .chargePhase, .pumpPhase, .targetMv, .thermalShutdown, .seqState);
`default_nettype wire

// file: verification/cpss_sequencer_tb.sv
// Testbench for the charge pump start-up sequencer
`default_nettype none
module cpss_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, srst = 1, pin = 0, stby = 0, en = 0, sel = 0;
  logic [7:0] temp = 8'h19;
  logic cp, pp, sd;
  logic [12:0] mv;
  logic [4:0] st;
  int n_fail = 0, check_count = 0;
  int nChg, nPmp, nBoth;
  // Row: multiplier select, then the target it must reach
  logic [13:0] rows [2] = '{{1'h0, 13'h1194}, {1'h1, 13'h1388}};
  always #20 clk_sys = ~clk_sys;
  cpss_sequencer dut_u (.clk_sys, .srst, .resetInputPin(pin),
    .standbyReleaseBit(stby), .pumpEnableBit(en), .multiplierSelect(sel),
    .junctionTemp(temp), .chargePhase(cp), .pumpPhase(pp), .targetMv(mv),
    .thermalShutdown(sd), .seqState(st));
  task automatic chk(string n, logic [12:0] e, logic [12:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Bounded so a stuck sequencer falls through to a failing compare
  task automatic waitState(logic [4:0] s);
    for (int i = 0; i < 30000 && st !== s; i++) @(negedge clk_sys);
  endtask
  initial begin
    repeat (85000) @(posedge clk_sys);
    n_fail++;
    test_done();
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    srst = 0;
    @(negedge clk_sys);
    chk("state", 13'h0002, 13'(st));
    foreach (rows[i]) begin
      sel = rows[i][13];
      stby = 1;
      en = 1;
      waitState(5'h08);
      repeat (2500) @(negedge clk_sys);
      chk("mid ramp", 13'(rows[i][12:1]), mv);
      waitState(5'h10);
      chk("target", rows[i][12:0], mv);
      repeat (64) @(negedge clk_sys);
      nChg = 0;
      nPmp = 0;
      nBoth = 0;
      repeat (64) begin
        @(negedge clk_sys);
        nChg += cp;
        nPmp += pp;
        nBoth += cp & pp;
      end
      chk("charge slots", 13'h0010, 13'(nChg));
      chk("pump slots", 13'h0010, 13'(nPmp));
      chk("overlap", 13'h0000, 13'(nBoth));
      en = 0;
      repeat (2) @(negedge clk_sys);
      chk("phases", 13'h0000, {11'h000, cp, pp});
    end
    en = 1;
    waitState(5'h10);
    temp = 8'hA0;
    repeat (3) @(negedge clk_sys);
    chk("shutdown", 13'h0001, {12'h000, sd});
    chk("phases", 13'h0000, {11'h000, cp, pp});
    temp = 8'h8D;
    repeat (3) @(negedge clk_sys);
    chk("shutdown", 13'h0001, {12'h000, sd});
    temp = 8'h8C;
    repeat (3) @(negedge clk_sys);
    chk("state", 13'h0004, 13'(st));
    pin = 1;
    repeat (4) @(negedge clk_sys);
    chk("state", 13'h0001, 13'(st));
    {pin, stby, en} = 3'h0;
    repeat (4) @(negedge clk_sys);
    chk("state", 13'h0002, 13'(st));
    test_done();
  end
endmodule
`default_nettype wire
